// *** pkg/shift_unit_map.vh ***
// register offsets, status word layout and reset values of the shift unit
`ifndef SHIFT_UNIT_MAP_VH
`define SHIFT_UNIT_MAP_VH

// register byte offsets
`define CTRL_OFFSET 12'h000
`define OPERAND_OFFSET 12'h004
`define COUNT_OFFSET 12'h008
`define STATUS_OFFSET 12'h00C
`define RESULT_OFFSET 12'h010
`define EXEC_COUNT_OFFSET 12'h014

// control register fields
`define CTRL_WIDE_BIT 0

// status word bit positions
`define FIRST_CHECK_BIT 0
`define LOGIC_OP_RESULT_BIT 1
`define STATUS_BIT_POS 2
`define OR_BIT_POS 3
`define STORED_OVERFLOW_BIT 4
`define OVERFLOW_BIT 5
`define CONDITION_CODE_LO_BIT 6
`define CONDITION_CODE_HI_BIT 7
`define BINARY_RESULT_BIT 8
`define STATUS_WIDTH 9

// reset values
`define CTRL_RESET 32'h00000000
`define OPERAND_RESET 32'h00000000
`define COUNT_RESET 16'h0000
`define STATUS_RESET 9'h000
`define RESULT_RESET 32'h00000000

// narrow and wide operand widths
`define NARROW_WIDTH 16
`define WIDE_WIDTH 32
`define COUNT_WIDTH 16

// bus answer timing: cycles from setup edge to pready
`define APB_WAIT_CYCLES 1

`endif

// *** design/sign_shift_core.v ***
// signed right shifter with count saturation and last-bit-out
`timescale 1ns/10ps

module sign_shift_core #(
  parameter WIDTH = 16,
  parameter CNT_W = 16
) (
  input wire [WIDTH-1:0] value_in,
  input wire [CNT_W-1:0] count_in,
  output wire [WIDTH-1:0] shifted_out,
  output wire last_bit_out,
  output wire count_nonzero
);

  localparam integer WIDTH_INT = WIDTH;
  // the width as a count value, cut to the count's own size
  localparam [CNT_W-1:0] WIDTH_CNT = WIDTH_INT[CNT_W-1:0];

  wire [CNT_W-1:0] count_sat;
  wire [CNT_W-1:0] count_less_one;
  wire signed [WIDTH-1:0] value_signed;
  wire signed [WIDTH-1:0] pre_shift;

  // counts beyond the width act as the width itself
  assign count_sat = (count_in > WIDTH_CNT) ? WIDTH_CNT : count_in;
  assign count_less_one = count_sat - {{(CNT_W-1){1'b0}}, 1'b1};
  assign value_signed = value_in;

  // vacated high bits take the sign bit
  assign shifted_out = value_signed >>> count_sat;

  // shifting one step less leaves the last bit out in position 0
  assign pre_shift = value_signed >>> count_less_one;
  assign count_nonzero = |count_in;
  assign last_bit_out = count_nonzero ? pre_shift[0] : 1'b0;

endmodule // sign_shift_core

// *** design/arith_shift_right_unit.v ***
// arithmetic right-shift unit with apb registers and status word update
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "shift_unit_map.vh"

module arith_shift_right_unit #(
  parameter NARROW_W = `NARROW_WIDTH,
  parameter WIDE_W = `WIDE_WIDTH,
  parameter CNT_W = `COUNT_WIDTH
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire box_enable_in,
  output reg box_enable_out,
  output reg [31:0] result_out,
  output reg [`STATUS_WIDTH-1:0] status_word_out
);

  // register state
  reg [31:0] ctrl_reg;
  reg [31:0] operand_reg;
  reg [CNT_W-1:0] count_reg;
  reg [31:0] exec_count_reg;
  reg [31:0] exec_count_next;
  reg [31:0] result_next;
  reg [`STATUS_WIDTH-1:0] status_next;

  // apb answer, prepared in the setup cycle
  reg pready_next;
  reg pslverr_next;
  reg [31:0] prdata_next;

  // bus decode
  wire setup_phase;
  wire access_done;
  wire bus_write;
  wire addr_mapped;
  wire addr_writable;
  wire hit_ctrl;
  wire hit_operand;
  wire hit_count;
  wire hit_status;
  wire hit_result;
  wire hit_exec;
  wire wr_ctrl;
  wire wr_operand;
  wire wr_count;
  wire wr_status;
  reg [31:0] read_mux;

  // shifter wires
  wire [NARROW_W-1:0] narrow_shifted;
  wire narrow_last;
  wire narrow_nonzero;
  wire [WIDE_W-1:0] wide_shifted;
  wire wide_last;
  wire wide_nonzero;
  wire wide_mode;

  // per-execution selected values
  reg [31:0] shift_value;
  reg last_out_bit;
  reg nonzero_count;
  wire exec_now;
  wire flag_clear;

  // zero padding above a narrow result
  localparam PAD_W = WIDE_W - NARROW_W;

  assign wide_mode = ctrl_reg[`CTRL_WIDE_BIT];

  // ------------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------------

  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign bus_write = access_done & pwrite;

  // one-hot decode of the full byte address
  assign hit_ctrl = (paddr == `CTRL_OFFSET);
  assign hit_operand = (paddr == `OPERAND_OFFSET);
  assign hit_count = (paddr == `COUNT_OFFSET);
  assign hit_status = (paddr == `STATUS_OFFSET);
  assign hit_result = (paddr == `RESULT_OFFSET);
  assign hit_exec = (paddr == `EXEC_COUNT_OFFSET);

  assign addr_mapped = hit_ctrl | hit_operand | hit_count | hit_status |
    hit_result | hit_exec;

  // result and execution count are read-only
  assign addr_writable = hit_ctrl | hit_operand | hit_count | hit_status;

  // write strobes, one per writable register
  assign wr_ctrl = bus_write & hit_ctrl;
  assign wr_operand = bus_write & hit_operand;
  assign wr_count = bus_write & hit_count;
  assign wr_status = bus_write & hit_status;

  // read data are picked from the address held in the setup cycle
  always @* begin
    case (paddr)
      `CTRL_OFFSET: begin
        read_mux = {31'h00000000, ctrl_reg[`CTRL_WIDE_BIT]};
      end
      `OPERAND_OFFSET: begin
        read_mux = operand_reg;
      end
      `COUNT_OFFSET: begin
        read_mux = {16'h0000, count_reg};
      end
      `STATUS_OFFSET: begin
        read_mux = {23'h000000, status_word_out};
      end
      `RESULT_OFFSET: begin
        read_mux = result_out;
      end
      `EXEC_COUNT_OFFSET: begin
        read_mux = exec_count_reg;
      end
      default: begin
        read_mux = 32'h00000000;
      end
    endcase
  end

  // one wait-free access phase: pready rises in the cycle after setup
  // and stands for exactly one cycle, with its data and error flag
  always @* begin
    pready_next = setup_phase;
    pslverr_next = 1'b0;
    prdata_next = 32'h00000000;
    if (setup_phase) begin
      if (pwrite) begin
        pslverr_next = ~addr_writable;
      end else begin
        pslverr_next = ~addr_mapped;
        prdata_next = read_mux;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= pready_next;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= pslverr_next;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= prdata_next;
    end
  end

  // mode bit selects the 32-bit variant
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= {31'h00000000, pwdata[`CTRL_WIDE_BIT]};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operand_reg <= `OPERAND_RESET;
    end else if (wr_operand) begin
      operand_reg <= pwdata;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= `COUNT_RESET;
    end else if (wr_count) begin
      count_reg <= pwdata[CNT_W-1:0];
    end
  end

  // ------------------------------------------------------------------
  // shifters
  // ------------------------------------------------------------------

  // narrow operand bits 0 to 15
  sign_shift_core #(
    .WIDTH(NARROW_W),
    .CNT_W(CNT_W)
  ) narrow_shift (
    .value_in(operand_reg[NARROW_W-1:0]),
    .count_in(count_reg),
    .shifted_out(narrow_shifted),
    .last_bit_out(narrow_last),
    .count_nonzero(narrow_nonzero)
  );

  sign_shift_core #(
    .WIDTH(WIDE_W),
    .CNT_W(CNT_W)
  ) wide_shift (
    .value_in(operand_reg[WIDE_W-1:0]),
    .count_in(count_reg),
    .shifted_out(wide_shifted),
    .last_bit_out(wide_last),
    .count_nonzero(wide_nonzero)
  );

  // narrow results sit in the low half, the high half reads zero
  always @* begin
    if (wide_mode) begin
      shift_value = wide_shifted;
      last_out_bit = wide_last;
      nonzero_count = wide_nonzero;
    end else begin
      shift_value = {{PAD_W{1'b0}}, narrow_shifted};
      last_out_bit = narrow_last;
      nonzero_count = narrow_nonzero;
    end
  end

  // ------------------------------------------------------------------
  // result and status word
  // ------------------------------------------------------------------

  assign exec_now = box_enable_in;
  // a nonzero count clears condition lo and overflow
  assign flag_clear = exec_now & nonzero_count;

  always @* begin
    result_next = result_out;
    if (exec_now) begin
      result_next = shift_value;
    end
  end

  // evaluations are counted for software, wrapping at the top
  always @* begin
    exec_count_next = exec_count_reg;
    if (exec_now) begin
      exec_count_next = exec_count_reg + 32'h00000001;
    end
  end

  // a software write is taken first; an execution in the same cycle
  // then overrides the bits that it owns
  always @* begin
    status_next = status_word_out;
    if (wr_status) begin
      status_next = pwdata[`STATUS_WIDTH-1:0];
    end
    // last bit out to condition hi
    if (flag_clear) begin
      status_next[`CONDITION_CODE_HI_BIT] = last_out_bit;
      status_next[`CONDITION_CODE_LO_BIT] = 1'b0;
      status_next[`OVERFLOW_BIT] = 1'b0;
    end
    // logic bits written, stored overflow kept, first check set
    if (exec_now) begin
      status_next[`BINARY_RESULT_BIT] = 1'b1;
      status_next[`OR_BIT_POS] = 1'b0;
      status_next[`STATUS_BIT_POS] = 1'b1;
      status_next[`LOGIC_OP_RESULT_BIT] = 1'b1;
      status_next[`FIRST_CHECK_BIT] = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_out <= `RESULT_RESET;
    end else begin
      result_out <= result_next;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exec_count_reg <= 32'h00000000;
    end else begin
      exec_count_reg <= exec_count_next;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_word_out <= `STATUS_RESET;
    end else begin
      status_word_out <= status_next;
    end
  end

  // one cycle behind the input, since every output leaves a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      box_enable_out <= 1'b0;
    end else begin
      box_enable_out <= box_enable_in;
    end
  end

endmodule // arith_shift_right_unit

// *** verification/arith_shift_right_unit_sva.sv ***
// port assertions for the shift unit
`timescale 1ns/10ps
`include "shift_unit_map.vh"
module shift_unit_sva (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire box_enable_in,
  input wire box_enable_out,
  input wire [31:0] result_out,
  input wire [`STATUS_WIDTH-1:0] status_word_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  reg [15:0] cnt_reg;
  wire wr = psel && penable && pready && pwrite;
  wire st_wr = wr && paddr == `STATUS_OFFSET;
  // shadow of the count register
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      cnt_reg <= 16'h0000;
    else if (wr && paddr == `COUNT_OFFSET)
      cnt_reg <= pwdata[15:0];
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence answer_s;
    pready ##1 !pready;
  endsequence
  a_apb_answer: assert property (setup_s |=> answer_s)
    else $error("pready not a pulse after setup");
  a_eno_follow: assert property (
    box_enable_out == $past(box_enable_in))
    else $error("enable out does not follow");
  a_idle_hold: assert property (
    !box_enable_in |=> $stable(result_out))
    else $error("result moved while idle");
  a_status_idle: assert property (
    !box_enable_in && !st_wr |=> $stable(status_word_out))
    else $error("status moved while idle");
  a_fixed_bits: assert property (box_enable_in |=>
    status_word_out[8] && status_word_out[3:0] == 4'h7)
    else $error("fixed status bits wrong");
  a_os_keep: assert property (
    box_enable_in && !st_wr |=> $stable(status_word_out[4]))
    else $error("stored overflow changed");
  a_cc_clear: assert property (
    box_enable_in && cnt_reg != 0 |=> status_word_out[6:5] == 2'h0)
    else $error("cc lo or overflow not cleared");
  a_zero_keep: assert property (
    box_enable_in && cnt_reg == 0 && !st_wr
    |=> $stable(status_word_out[7:5]))
    else $error("zero count changed flags");
endmodule // shift_unit_sva

bind arith_shift_right_unit shift_unit_sva chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .box_enable_in(box_enable_in), .box_enable_out(box_enable_out),
  .result_out(result_out), .status_word_out(status_word_out));

// *** verification/seq_model.sv ***
// sequencer model raising the box enable for a burst
`timescale 1ns/10ps
module seq_model (
  input wire pclk,
  input wire presetn,
  input wire start,
  input wire [1:0] burst,
  output reg box_enable_in
);
  reg [1:0] left_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      box_enable_in <= 1'b0;
      left_reg <= 2'h0;
    end else if (start) begin
      box_enable_in <= 1'b1;
      left_reg <= burst;
    end else if (left_reg > 2'h1) begin
      left_reg <= left_reg - 2'h1;
    end else begin
      box_enable_in <= 1'b0;
      left_reg <= 2'h0;
    end
  end
endmodule // seq_model

// *** verification/tb_arith_shift_right_unit.sv ***
// self-checking bench for the shift unit
`timescale 1ns/10ps
`include "shift_unit_map.vh"
module tb_arith_shift_right_unit;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic start = 0, box_enable_in, box_enable_out, pready, pslverr, er;
  logic [1:0] burst = 2'h1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, result_out, rd, last_r = 0;
  logic [`STATUS_WIDTH-1:0] status_word_out, st = 0;
  logic [40:0] q[$];
  logic [15:0] cnts [10] = '{16'h0000, 16'h0001, 16'h000F, 16'h0010,
    16'h0011, 16'h001F, 16'h0020, 16'h0021, 16'hFFFF, 16'h0005};
  int n_mismatch = 0, comparisons = 0, cyc = 0, n_eval = 0;
  always #20 pclk = ~pclk;
  arith_shift_right_unit DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .box_enable_in(box_enable_in),
    .box_enable_out(box_enable_out), .result_out(result_out),
    .status_word_out(status_word_out));
  seq_model seq (.pclk(pclk), .presetn(presetn), .start(start),
    .burst(burst), .box_enable_in(box_enable_in));
  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic [40:0] e, input logic [40:0] s);
    comparisons++;
    if (s !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, s);
      n_mismatch++;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input logic w, input logic [31:0] op,
                     input logic [15:0] c, input logic [1:0] b);
    int n;
    logic signed [31:0] s;
    logic [31:0] r;
    apb(1, `CTRL_OFFSET, {31'h0, w});
    apb(1, `OPERAND_OFFSET, op);
    apb(1, `COUNT_OFFSET, {16'h0, c});
    n = (c > (w ? 32 : 16)) ? (w ? 32 : 16) : c;
    s = w ? op : {{16{op[15]}}, op[15:0]};
    r = s >>> n;
    if (!w)
      r[31:16] = 16'h0000;
    if (n != 0)
      st[7:5] = {op[n-1], 2'h0};
    st[8] = 1'b1;
    st[3:0] = 4'h7;
    last_r = r;
    repeat (b) q.push_back({r, st});
    n_eval += b;
    @(posedge pclk);
    burst <= b;
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    repeat (b) @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    if (box_enable_out === 1'b1) begin
      if (q.size() == 0)
        chk("extra result", 0, 1);
      else
        chk("result", q.pop_front(), {result_out, status_word_out});
    end
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    void'($urandom(95556));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 24; i += 4) begin
      apb(0, i[11:0], 0);
      chk("reset value", 0, {er, rd});
    end
    apb(0, 12'h020, 0);
    chk("unmapped read", {1'b1, 32'h0}, {er, rd});
    apb(1, `RESULT_OFFSET, 32'hFFFFFFFF);
    chk("read-only write", 1, er);
    $display("test registers done");
    for (int k = 0; k < 20; k++) begin
      rd = $urandom | {k[2], 15'h0000, k[2], 15'h0000};
      run(k[0], rd, cnts[k / 2], 2'(1 + k % 3));
    end
    $display("test shifts done");
    apb(1, `STATUS_OFFSET, 32'h00000070);
    st = 9'h070;
    run(1, 32'h80000001, 16'h0000, 2'h2);
    repeat (5) @(posedge pclk);
    apb(0, `RESULT_OFFSET, 0);
    chk("result register", last_r, rd);
    apb(0, `STATUS_OFFSET, 0);
    chk("status register", st, rd);
    chk("pending results", 0, q.size());
    apb(0, `EXEC_COUNT_OFFSET, 0);
    chk("evaluation count", n_eval, rd);
    $display("test zero count done");
    conclude();
  end
endmodule // tb_arith_shift_right_unit
